// ===== src/dispc_pkg.sv
package dispc_pkg;

  // ---------------------------------------------------------------
  // Port addresses and widths
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 10;
  localparam logic [ADDR_W-1:0] ADDR_INT_CTRL  = 4'h7;
  localparam logic [ADDR_W-1:0] ADDR_SYS_CTRL  = 4'hc;

  // ---------------------------------------------------------------
  // Interrupt control/status field positions
  // ---------------------------------------------------------------
  localparam int unsigned ICS_CLEAR_WIDEBAND_IRQ  = 9;
  localparam int unsigned ICS_SYM_DIS    = 8;
  localparam int unsigned ICS_CLEAR_C    = 7;
  localparam int unsigned ICS_SEND_D     = 6;
  localparam int unsigned ICS_SEND_F     = 5;
  localparam logic [DATA_W-1:0] ICS_RESET = 10'h100;

  // ---------------------------------------------------------------
  // System status/control field positions
  // ---------------------------------------------------------------
  localparam int unsigned SSC_TX_GO      = 9;
  localparam int unsigned SSC_MODE       = 8;
  localparam int unsigned SSC_CODEC      = 7;
  localparam int unsigned SSC_FM_VOICE   = 6;
  localparam int unsigned SSC_FM_RX      = 5;
  localparam int unsigned SSC_IQ_RX      = 4;
  localparam int unsigned SSC_TX_PWR     = 3;
  localparam int unsigned SSC_GEN_OUT    = 2;
  localparam int unsigned SSC_RX_OFFSET  = 1;
  localparam int unsigned SSC_LOOPBACK   = 0;
  localparam logic [DATA_W-1:0] SSC_RESET = 10'h000;
  // Write-only bit reads back as zero
  localparam logic [DATA_W-1:0] SSC_READ_MASK = 10'h3fb;

  // ---------------------------------------------------------------
  // Grouped signals
  // ---------------------------------------------------------------
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } dispc_req_type;

  typedef struct packed {
    logic transmit_go;
    logic digital_mode;
    logic codec_enable;
    logic fm_voice_select;
    logic fm_receiver_enable;
    logic iq_receiver_power;
    logic transmitter_power;
    logic general_output;
    logic receive_offset_measure;
    logic analog_loopback;
  } dispc_ctrl_type;

  typedef struct packed {
    logic wideband_data;
    logic int_c;
    logic int_d;
    logic int_f;
  } dispc_irq_type;

endpackage

// ===== src/dispc_regs.sv
`timescale 1ns/10ps
// Notes on behaviour
// - Writing 1 performs the named bit action
// - Reading clear/raise bits shows pending state
// - Writing 0 changes nothing, except to bit 8, which re-enables
// - Clear bit drops pending flag and pin
// - Raise bit asserts pin until reset; no bit clears it
// - Disable bit suppresses symbol interrupt output
// - Disable changes only at pulse boundaries
// - Disable bit reads 1 after reset
// - Transmit go frames digital bursts
// - Mode bit selects digital or analog
// - Codec bit enables codec and its clocks
// - FM voice enables Q side from FM
// - FM receiver enable follows bit 5
// - Bit 4 powers I and Q receivers
// - Bit 3 powers the transmitter
// - Bit 2 write-only, drives general output
// - Offset bit shorts receive inputs internally
// - Loopback feeds receive with attenuated transmit
// - Reset values for both registers
// - Port addresses 07h and 0Ch
module dispc_regs
  import dispc_pkg::*;
(
  input  wire logic                     core_clk,
  input  wire logic                     rst,
  input  wire dispc_pkg::dispc_req_type req,
  output logic [dispc_pkg::DATA_W-1:0]  rdata,
  input  wire logic                     wideband_event,
  input  wire logic                     int_c_event,
  input  wire logic                     symbol_raw,
  output dispc_pkg::dispc_irq_type      irq_out,
  output logic                          symbol_interrupt,
  output dispc_pkg::dispc_ctrl_type     ctrl,
  output logic                          codec_clk_run,
  output logic                          burst_active,
  output logic                          q_from_fm,
  output logic                          rx_pins_connected
);
  import dispc_pkg::*;

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  logic wr_ics;
  logic wr_ssc;
  logic sym_dis_req;
  logic sym_dis_eff;
  logic sym_prev;
  logic [DATA_W-1:0] ssc;

  assign wr_ics = req.wr && (req.addr == ADDR_INT_CTRL);
  assign wr_ssc = req.wr && (req.addr == ADDR_SYS_CTRL);

  // ---------------------------------------------------------------
  // Pending interrupts
  // ---------------------------------------------------------------
  // Hardware set wins over a same-cycle software clear
  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq_out <= '0;
    end else begin
      if (wideband_event) begin
        irq_out.wideband_data <= 1'b1;
      end else if (wr_ics && req.wdata[ICS_CLEAR_WIDEBAND_IRQ]) begin
        irq_out.wideband_data <= 1'b0;
      end
      if (int_c_event) begin
        irq_out.int_c <= 1'b1;
      end else if (wr_ics && req.wdata[ICS_CLEAR_C]) begin
        irq_out.int_c <= 1'b0;
      end
      if (wr_ics && req.wdata[ICS_SEND_D]) begin
        irq_out.int_d <= 1'b1;
      end
      if (wr_ics && req.wdata[ICS_SEND_F]) begin
        irq_out.int_f <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Symbol interrupt gating
  // ---------------------------------------------------------------
  // Disable is a stored control bit, so software can also re-enable
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sym_dis_req <= 1'b1;
    end else if (wr_ics) begin
      sym_dis_req <= req.wdata[ICS_SYM_DIS];
    end
  end

  // Applied only while the raw symbol line is idle, so an active
  // period is never cut short or started mid-way.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sym_dis_eff <= 1'b1;
      sym_prev    <= 1'b0;
      symbol_interrupt <= 1'b0;
    end else begin
      sym_prev <= symbol_raw;
      if (!symbol_raw && !sym_prev) begin
        sym_dis_eff <= sym_dis_req;
      end
      symbol_interrupt <= symbol_raw && !sym_dis_eff;
    end
  end

  // ---------------------------------------------------------------
  // System status/control
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ssc <= SSC_RESET;
    end else if (wr_ssc) begin
      ssc <= req.wdata;
    end
  end

  assign ctrl.transmit_go            = ssc[SSC_TX_GO];
  assign ctrl.digital_mode           = ssc[SSC_MODE];
  assign ctrl.codec_enable           = ssc[SSC_CODEC];
  assign ctrl.fm_voice_select        = ssc[SSC_FM_VOICE];
  assign ctrl.fm_receiver_enable     = ssc[SSC_FM_RX];
  assign ctrl.iq_receiver_power      = ssc[SSC_IQ_RX];
  assign ctrl.transmitter_power      = ssc[SSC_TX_PWR];
  assign ctrl.general_output         = ssc[SSC_GEN_OUT];
  assign ctrl.receive_offset_measure = ssc[SSC_RX_OFFSET];
  assign ctrl.analog_loopback        = ssc[SSC_LOOPBACK];

  // Burst only meaningful in digital mode
  assign burst_active  = ssc[SSC_TX_GO] && ssc[SSC_MODE];
  assign codec_clk_run = ssc[SSC_CODEC];
  assign q_from_fm     = ssc[SSC_FM_VOICE];
  // Either test path takes the pins off the receive channel
  assign rx_pins_connected = !(ssc[SSC_RX_OFFSET] || ssc[SSC_LOOPBACK]);

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdata <= '0;
    end else if (req.rd) begin
      case (req.addr)
        ADDR_INT_CTRL: begin
          rdata <= {irq_out.wideband_data, sym_dis_req, irq_out.int_c,
                    irq_out.int_d, irq_out.int_f, 5'h00};
        end
        ADDR_SYS_CTRL: begin
          rdata <= ssc & SSC_READ_MASK;
        end
        default: begin
          rdata <= '0;
        end
      endcase
    end
  end

endmodule

// ===== verification/dispc_dsp_model.sv
`timescale 1ns/10ps
module dispc_dsp_model
(
  input  wire logic                         core_clk,
  input  wire logic [dispc_pkg::DATA_W-1:0] rdata,
  output dispc_pkg::dispc_req_type          req
);
  import dispc_pkg::*;
  initial req = '0;
  // Released bus shows inverted values, never the last request
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge core_clk);
    req <= '{1'b1, 1'b0, a, d};
    @(posedge core_clk);
    req <= '{1'b0, 1'b0, ~a, ~d};
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge core_clk);
    req <= '{1'b0, 1'b1, a, 10'h155};
    @(posedge core_clk);
    req <= '{1'b0, 1'b0, ~a, 10'h2aa};
    @(posedge core_clk);
    d = rdata;
  endtask
endmodule

// ===== verification/dispc_regs_asserts.sv
`timescale 1ns/10ps
module dispc_regs_asserts
(
  input wire logic                        core_clk,
  input wire logic                        rst,
  input wire dispc_pkg::dispc_req_type    req,
  input wire logic [dispc_pkg::DATA_W-1:0] rdata,
  input wire logic                        wideband_event,
  input wire logic                        int_c_event,
  input wire logic                        symbol_raw,
  input wire dispc_pkg::dispc_irq_type    irq_out,
  input wire logic                        symbol_interrupt,
  input wire dispc_pkg::dispc_ctrl_type   ctrl,
  input wire logic                        rx_pins_connected
);
  import dispc_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic ics_wr;
  logic ssc_wr;
  logic no_ev;
  assign ics_wr = req.wr && req.addr == ADDR_INT_CTRL;
  assign ssc_wr = req.wr && req.addr == ADDR_SYS_CTRL;
  assign no_ev  = !wideband_event && !int_c_event;
  a_raise_d: assert property (
    ics_wr && req.wdata[6] |=> irq_out.int_d) else $error("d not raised");
  a_clear_c: assert property (
    ics_wr && req.wdata[7] && no_ev |=> !irq_out.int_c) else $error("c not cleared");
  a_zero_keep: assert property (
    ics_wr && req.wdata == 10'h000 && no_ev |=> $stable(irq_out)) else $error("zero acted");
  a_read_pend: assert property (
    req.rd && req.addr == ADDR_INT_CTRL |=> rdata[4:0] == 5'h00
    && rdata[6] == $past(irq_out.int_d)) else $error("bad pending read");
  a_ctrl_load: assert property (
    ssc_wr |=> ctrl == $past(req.wdata)) else $error("ctrl not loaded");
  a_rx_iso: assert property (
    rx_pins_connected == !(ctrl.receive_offset_measure || ctrl.analog_loopback))
    else $error("rx pins wrong");
  a_sym_gate: assert property (
    !symbol_raw |=> !symbol_interrupt) else $error("symbol without source");
  a_sym_whole: assert property (
    symbol_interrupt && symbol_raw |=> symbol_interrupt) else $error("symbol pulse cut");
  a_bad_addr: assert property (
    req.rd && req.addr != ADDR_INT_CTRL && req.addr != ADDR_SYS_CTRL |=> rdata == 10'h000)
    else $error("unmapped read");
endmodule
bind dispc_regs dispc_regs_asserts chk (.core_clk, .rst, .req, .rdata, .wideband_event,
  .int_c_event, .symbol_raw, .irq_out, .symbol_interrupt, .ctrl, .rx_pins_connected);

// ===== verification/tb.sv
`timescale 1ns/10ps
module tb;
  import dispc_pkg::*;
  logic                 core_clk;
  logic                 rst;
  logic                 wideband_event;
  logic                 int_c_event;
  logic                 symbol_raw;
  logic [DATA_W-1:0]    rdata;
  logic [DATA_W-1:0]    rv;
  dispc_req_type        req;
  dispc_irq_type        irq_out;
  dispc_ctrl_type       ctrl;
  logic                 symbol_interrupt;
  logic                 codec_clk_run;
  logic                 burst_active;
  logic                 q_from_fm;
  logic                 rx_pins_connected;
  int                   n_errors;
  int                   samples_checked;
  dispc_regs uut (.core_clk, .rst, .req, .rdata, .wideband_event, .int_c_event,
    .symbol_raw, .irq_out, .symbol_interrupt, .ctrl, .codec_clk_run,
    .burst_active, .q_from_fm, .rx_pins_connected);
  dispc_dsp_model dsp (.core_clk, .rdata, .req);
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  task automatic chk(input logic [DATA_W-1:0] g, input logic [DATA_W-1:0] e);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                        input logic [DATA_W-1:0] e);
    dsp.wr(a, d);
    dsp.rd(a, rv);
    chk(rv, e);
  endtask
  task automatic t_reset;
    dsp.rd(ADDR_INT_CTRL, rv);
    chk(rv, 10'h100);
    dsp.rd(ADDR_SYS_CTRL, rv);
    chk(rv, 10'h000);
    chk({9'h0, rx_pins_connected}, 10'h001);
    $display("reset test done");
  endtask
  task automatic t_ctrl;
    wr_chk(ADDR_SYS_CTRL, 10'h3ff, 10'h3fb);
    chk(ctrl, 10'h3ff);
    chk({codec_clk_run, rx_pins_connected}, 10'h002);
    chk({burst_active, q_from_fm}, 10'h003);
    wr_chk(ADDR_SYS_CTRL, 10'h200, 10'h200);
    chk({burst_active, q_from_fm}, 10'h000);
    wr_chk(ADDR_SYS_CTRL, 10'h004, 10'h000);
    chk({ctrl.general_output, rx_pins_connected}, 10'h003);
    wr_chk(ADDR_SYS_CTRL, 10'h000, 10'h000);
    $display("control test done");
  endtask
  task automatic t_irq;
    @(posedge core_clk);
    wideband_event <= 1'b1;
    int_c_event <= 1'b1;
    @(posedge core_clk);
    wideband_event <= 1'b0;
    int_c_event <= 1'b0;
    wr_chk(ADDR_INT_CTRL, 10'h000, 10'h280);
    wr_chk(ADDR_INT_CTRL, 10'h060, 10'h2e0);
    chk({6'h0, irq_out}, 10'h00f);
    wr_chk(ADDR_INT_CTRL, 10'h280, 10'h060);
    chk({6'h0, irq_out}, 10'h003);
    wr_chk(ADDR_INT_CTRL, 10'h01f, 10'h060);
    $display("interrupt test done");
  endtask
  task automatic t_sym;
    @(posedge core_clk);
    symbol_raw <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk({9'h0, symbol_interrupt}, 10'h001);
    wr_chk(ADDR_INT_CTRL, 10'h100, 10'h160);
    chk({9'h0, symbol_interrupt}, 10'h001);
    symbol_raw <= 1'b0;
    repeat (3) @(posedge core_clk);
    symbol_raw <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk({9'h0, symbol_interrupt}, 10'h000);
    symbol_raw <= 1'b0;
    wr_chk(4'h3, 10'h3ff, 10'h000);
    $display("symbol test done");
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #50000;
    n_errors++;
    test_done;
  end
  initial begin
    rst = 1'b1;
    wideband_event = 1'b0;
    int_c_event = 1'b0;
    symbol_raw = 1'b0;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    t_reset;
    t_ctrl;
    t_irq;
    t_sym;
    test_done;
  end
endmodule
